// file: core/ptu_event_logic.sv
// Event, request routing and access conflict logic of the six-channel timer.
//
// Functional notes
// - Every channel's overflow sets its overflow flag; request while enabled.
// - Channels 1, 2, 4, 5 detect underflow, set flag, request while enabled.
// - Overflow and underflow requests stay until their flag is cleared.
// - All sixteen capture/compare events can request the transfer controller.
// - Only each channel's first register event requests the DMA controller.
// - First flag set with A/D trigger enabled sends a conversion start.
// - Match fires as counter leaves matched value; programmed pin level follows.
// - No further match until the next counter input clock.
// - Software clears a flag by reading it as one, then writing zero.
// - Transfer start clears the flag and its request on the next clock.
// - Next request masked until later of transfer end or five clocks.
// - Unit starts in module stop; registers accessible once stop cleared.
// - Clear on match acts in last matching cycle, period is value plus one.
// - Counter clear wins over a simultaneous counter write.
// - Counter write wins over a simultaneous increment.
// - Compare register write suppresses a coinciding match.
// - Buffer transfer on match carries data written in the same cycle.
// - Capture during a register read returns the newly captured value.
// - Capture wins over a simultaneous compare register write.
// - Buffer transfer on capture wins over a simultaneous buffer write.
// - Overflow or underflow coinciding with counter clear sets no flag.
// - Counter write coinciding with overflow or underflow sets no flag.
// - Each capture or compare event sets its flag, requests while enabled.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module ptu_event_logic
    import ptu_pkg::*;
#(
    parameter logic [2:0] XFER_MASK = `PTU_XFER_MASK_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ptu_bus_t bus,
    input wire logic [5:0] count_tick,
    input wire logic [5:0] count_down,
    input wire logic [15:0] capture_in,
    input wire logic [15:0] xfer_start,
    input wire logic [15:0] xfer_end,
    input wire logic [5:0] dma_start,
    input wire logic [5:0] dma_end,
    output logic [15:0] rdata,
    output logic [15:0] capture_match_irq,
    output logic [5:0] overflow_irq,
    output logic [5:0] underflow_irq,
    output logic [15:0] xfer_req,
    output logic [5:0] dma_req,
    output logic adc_start,
    output logic [15:0] timer_io_pin
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ****************************************************************
    // Module stop and bus read path
    // ****************************************************************
    logic mstop_r;
    logic mstop_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic adc_r;
    logic adc_nxt;
    logic acc_ok;
    logic [15:0] rd_ch [6];
    logic [5:0] adc_hit;

    // Stopped unit ignores all accesses except to the stop control itself.
    assign acc_ok = ~mstop_r;

    always_comb
    begin
        mstop_nxt = mstop_r;
        rdata_nxt = 16'h0000;
        adc_nxt = |adc_hit;
        if (bus.wr && bus.addr == `PTU_ADDR_MSTOP)
            mstop_nxt = bus.wdata[0];
        if (bus.rd)
        begin
            if (bus.addr == `PTU_ADDR_MSTOP)
                rdata_nxt = {15'h0000, mstop_r};
            else if (acc_ok && bus.addr[7:4] < `PTU_NUM_CH)
                rdata_nxt = rd_ch[bus.addr[6:4]];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mstop_r <= `PTU_MSTOP_RST;
            rdata_r <= 16'h0000;
            adc_r <= 1'b0;
        end
        else
        begin
            mstop_r <= mstop_nxt;
            rdata_r <= rdata_nxt;
            adc_r <= adc_nxt;
        end
    end
    assign rdata = rdata_r;
    assign adc_start = adc_r;

    // ****************************************************************
    // Per-channel counter, registers, flags and requests
    // ****************************************************************
    for (genvar ch = 0; ch < 6; ch++)
    begin : ch_g
        localparam int NGR = (ch == 0 || ch == 3) ? 4 : 2;
        localparam bit HAS_UDF = !(ch == 0 || ch == 3);
        localparam int SB = (ch == 0) ? 0 : (ch == 1) ? 4 : (ch == 2) ? 6 :
                            (ch == 3) ? 8 : (ch == 4) ? 12 : 14;
        localparam logic [5:0] FLG_OK = {HAS_UDF, 1'b1,
                                         (NGR == 4) ? 4'hF : 4'h3};

        logic [15:0] cnt_r, cnt_nxt;
        logic [15:0] gr_r [4];
        logic [15:0] gr_nxt [4];
        logic [2:0] ioc_r [4];
        logic [2:0] ioc_nxt [4];
        logic [4:0] ctl_r, ctl_nxt;
        logic [11:0] ien_r, ien_nxt;
        logic [5:0] flg_r, flg_nxt;
        logic [5:0] arm_r, arm_nxt;
        logic [5:0] irq_r, irq_nxt;
        logic [3:0] xreq_r, xreq_nxt;
        logic dreq_r, dreq_nxt;
        logic [3:0] pin_r, pin_nxt;
        logic [2:0] xm_r [4];
        logic [2:0] xm_nxt [4];
        logic [3:0] xb_r, xb_nxt;
        logic [2:0] dm_r, dm_nxt;
        logic db_r, db_nxt;
        logic [15:0] rd_val;
        logic sel, wr_ctl, wr_ien, wr_sts, wr_cnt, rd_sts;
        logic [3:0] wr_gr, wr_ioc, match, cap, active;
        logic [5:0] flg_set, flg_clr;
        logic run, tick, dn, clr, buf_on;
        logic [2:0] clr_sel;
        logic adc_bit;
        logic [3:0] cap_src, xs_src, xe_src;

        always_comb
        begin
            sel = acc_ok && bus.addr[7:4] == 4'(ch);
            wr_ctl = sel && bus.wr && bus.addr[3:0] == `PTU_REG_CTL;
            wr_ien = sel && bus.wr && bus.addr[3:0] == `PTU_REG_IEN;
            wr_sts = sel && bus.wr && bus.addr[3:0] == `PTU_REG_STS;
            rd_sts = sel && bus.rd && bus.addr[3:0] == `PTU_REG_STS;
            wr_cnt = sel && bus.wr && bus.addr[3:0] == `PTU_REG_CNT;
            run = acc_ok && ctl_r[`PTU_CTL_RUN];
            tick = run && count_tick[ch];
            dn = HAS_UDF && count_down[ch];
            buf_on = (NGR == 4) && ctl_r[`PTU_CTL_BUF];
            clr_sel = ctl_r[`PTU_CTL_CLR_LSB+:3];
            clr = 1'b0;
            flg_set = 6'h00;
            for (int g = 0; g < 4; g++)
            begin
                active[g] = (g < NGR) && !(buf_on && g >= 2);
                wr_gr[g] = sel && bus.wr && (g < NGR) &&
                           bus.addr[3:0] == `PTU_REG_GR0 + 4'(g);
                wr_ioc[g] = sel && bus.wr && (g < NGR) &&
                            bus.addr[3:0] == `PTU_REG_IOC0 + 4'(g);
                // Match only on a counter clock, so a rewrite of the same
                // value can never produce one on its own.
                match[g] = active[g] && tick && !ioc_r[g][`PTU_IOC_CAP] &&
                           cnt_r == gr_r[g] && !wr_gr[g];
                cap[g] = active[g] && run && ioc_r[g][`PTU_IOC_CAP] &&
                         cap_src[g];
                flg_set[g] = match[g] || cap[g];
                if (clr_sel == 3'(g + 1) && (match[g] || cap[g]))
                    clr = 1'b1;
            end
            // Counter next value: clear beats write, write beats count.
            cnt_nxt = cnt_r;
            if (clr)
                cnt_nxt = 16'h0000;
            else if (wr_cnt)
                cnt_nxt = bus.wdata;
            else if (tick && dn)
                cnt_nxt = cnt_r - 16'h0001;
            else if (tick)
                cnt_nxt = cnt_r + 16'h0001;
            flg_set[`PTU_FLG_OVF] = tick && !dn && cnt_r == `PTU_CNT_MAX &&
                                    !clr && !wr_cnt;
            flg_set[`PTU_FLG_UDF] = tick && dn && cnt_r == 16'h0000 &&
                                    !clr && !wr_cnt;
            // General registers, buffers and compare outputs.
            pin_nxt = pin_r;
            for (int g = 0; g < 4; g++)
            begin
                ioc_nxt[g] = wr_ioc[g] ? bus.wdata[2:0] : ioc_r[g];
                gr_nxt[g] = wr_gr[g] ? bus.wdata : gr_r[g];
            end
            for (int g = 0; g < 2; g++)
            begin
                if (buf_on && match[g])
                    gr_nxt[g] = wr_gr[g+2] ? bus.wdata : gr_r[g+2];
                if (buf_on && cap[g])
                    gr_nxt[g+2] = gr_r[g];
            end
            for (int g = 0; g < 4; g++)
            begin
                if (cap[g])
                    gr_nxt[g] = cnt_r;
                if (match[g])
                begin
                    case (ptu_pin_act_t'(ioc_r[g][2:1]))
                        PTU_PIN_LOW: pin_nxt[g] = 1'b0;
                        PTU_PIN_HIGH: pin_nxt[g] = 1'b1;
                        PTU_PIN_TOGGLE: pin_nxt[g] = ~pin_r[g];
                        default: pin_nxt[g] = pin_r[g];
                    endcase
                end
            end
            ctl_nxt = wr_ctl ? bus.wdata[4:0] : ctl_r;
            ien_nxt = wr_ien ? bus.wdata[11:0] : ien_r;
            // Flag clearing by software or transfer start; set wins.
            flg_clr = 6'h00;
            for (int i = 0; i < 6; i++)
            begin
                flg_clr[i] = wr_sts && !bus.wdata[i] && arm_r[i];
            end
            for (int g = 0; g < 4; g++)
            begin
                flg_clr[g] = flg_clr[g] || xs_src[g];
            end
            flg_clr[0] = flg_clr[0] || dma_start[ch];
            flg_nxt = (flg_set | (flg_r & ~flg_clr)) & FLG_OK;
            if (wr_sts)
                arm_nxt = 6'h00;
            else if (rd_sts)
                arm_nxt = arm_r | flg_nxt;
            else
                arm_nxt = arm_r;
            // Transfer masking runs five clocks from start, or to the end.
            for (int g = 0; g < 4; g++)
            begin
                xm_nxt[g] = (xm_r[g] != 3'h0) ? xm_r[g] - 3'h1 : 3'h0;
                xb_nxt[g] = xb_r[g];
                if (xe_src[g])
                    xb_nxt[g] = 1'b0;
                if (xs_src[g])
                begin
                    xm_nxt[g] = XFER_MASK - 3'h1;
                    xb_nxt[g] = 1'b1;
                end
                xreq_nxt[g] = flg_nxt[g] && ien_nxt[`PTU_IEN_XFR_LSB+g] &&
                              xm_nxt[g] == 3'h0 && !xb_nxt[g];
            end
            dm_nxt = (dm_r != 3'h0) ? dm_r - 3'h1 : 3'h0;
            db_nxt = dma_end[ch] ? 1'b0 : db_r;
            if (dma_start[ch])
            begin
                dm_nxt = XFER_MASK - 3'h1;
                db_nxt = 1'b1;
            end
            dreq_nxt = flg_nxt[0] && ien_nxt[`PTU_IEN_DMA] &&
                       dm_nxt == 3'h0 && !db_nxt;
            irq_nxt = flg_nxt & ien_nxt[5:0];
            adc_bit = flg_nxt[0] && !flg_r[0] &&
                          ien_r[`PTU_IEN_ADC];
            // Reads show the values after this cycle's events.
            case (bus.addr[3:0])
                `PTU_REG_CTL: rd_val = {11'h000, ctl_r};
                `PTU_REG_IEN: rd_val = {4'h0, ien_r};
                `PTU_REG_STS: rd_val = {10'h000, flg_nxt};
                `PTU_REG_CNT: rd_val = cnt_nxt;
                4'h4, 4'h5, 4'h6, 4'h7:
                    // The index is widened, as a two-bit four wraps to zero.
                    rd_val = ({1'b0, bus.addr[1:0]} < 3'(NGR)) ?
                             gr_nxt[bus.addr[1:0]] : 16'h0000;
                4'h8, 4'h9, 4'hA, 4'hB:
                    rd_val = ({1'b0, bus.addr[1:0]} < 3'(NGR)) ?
                             {13'h0000, ioc_r[bus.addr[1:0]]} : 16'h0000;
                default: rd_val = 16'h0000;
            endcase
        end
        assign rd_ch[ch] = rd_val;
        assign adc_hit[ch] = adc_bit;

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cnt_r <= 16'h0000;
                ctl_r <= 5'h00;
                ien_r <= 12'h000;
                flg_r <= 6'h00;
                arm_r <= 6'h00;
                irq_r <= 6'h00;
                xreq_r <= 4'h0;
                dreq_r <= 1'b0;
                pin_r <= 4'h0;
                xb_r <= 4'h0;
                dm_r <= 3'h0;
                db_r <= 1'b0;
                for (int g = 0; g < 4; g++)
                begin
                    gr_r[g] <= `PTU_GR_RST;
                    ioc_r[g] <= 3'h0;
                    xm_r[g] <= 3'h0;
                end
            end
            else
            begin
                cnt_r <= cnt_nxt;
                ctl_r <= ctl_nxt;
                ien_r <= ien_nxt;
                flg_r <= flg_nxt;
                arm_r <= arm_nxt;
                irq_r <= irq_nxt;
                xreq_r <= xreq_nxt;
                dreq_r <= dreq_nxt;
                pin_r <= pin_nxt;
                xb_r <= xb_nxt;
                dm_r <= dm_nxt;
                db_r <= db_nxt;
                for (int g = 0; g < 4; g++)
                begin
                    gr_r[g] <= gr_nxt[g];
                    ioc_r[g] <= ioc_nxt[g];
                    xm_r[g] <= xm_nxt[g];
                end
            end
        end

        assign overflow_irq[ch] = irq_r[`PTU_FLG_OVF];
        assign underflow_irq[ch] = irq_r[`PTU_FLG_UDF];
        assign dma_req[ch] = dreq_r;
        for (genvar g = 0; g < NGR; g++)
        begin : src_g
            assign capture_match_irq[SB+g] = irq_r[g];
            assign xfer_req[SB+g] = xreq_r[g];
            assign timer_io_pin[SB+g] = pin_r[g];
            assign cap_src[g] = capture_in[SB+g];
            assign xs_src[g] = xfer_start[SB+g];
            assign xe_src[g] = xfer_end[SB+g];
        end
        // Registers C and D are missing on short channels, so see no events.
        if (NGR == 2)
        begin : pad_g
            assign cap_src[3:2] = 2'h0;
            assign xs_src[3:2] = 2'h0;
            assign xe_src[3:2] = 2'h0;
        end
    end

endmodule : ptu_event_logic

// file: core/ptu_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer.
`ifndef PTU_CFG_SVH
`define PTU_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PTU_DW 16
`define PTU_AW 8
`define PTU_REG_CTL 4'h0
`define PTU_REG_IEN 4'h1
`define PTU_REG_STS 4'h2
`define PTU_REG_CNT 4'h3
`define PTU_REG_GR0 4'h4
`define PTU_REG_IOC0 4'h8
`define PTU_NUM_CH 4'h6
`define PTU_ADDR_MSTOP 8'h60

// ****************************************************************
// Field positions
// ****************************************************************
`define PTU_CTL_CLR_LSB 0
`define PTU_CTL_BUF 3
`define PTU_CTL_RUN 4
`define PTU_IEN_OVF 4
`define PTU_IEN_UDF 5
`define PTU_IEN_ADC 6
`define PTU_IEN_DMA 7
`define PTU_IEN_XFR_LSB 8
`define PTU_FLG_OVF 4
`define PTU_FLG_UDF 5
`define PTU_IOC_CAP 0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PTU_MSTOP_RST 1'b1
`define PTU_GR_RST 16'h0000
`define PTU_CNT_MAX 16'hFFFF
`define PTU_XFER_MASK_CYC 3'h5

`endif

// file: core/ptu_pkg.sv
// Types shared by the timer event logic and its bench.
`include "ptu_cfg.svh"
package ptu_pkg;

    typedef struct packed {
        logic [`PTU_AW-1:0] addr;
        logic [`PTU_DW-1:0] wdata;
        logic wr;
        logic rd;
    } ptu_bus_t;

    typedef enum logic [1:0] {
        PTU_PIN_HOLD = 2'h0,
        PTU_PIN_LOW = 2'h1,
        PTU_PIN_HIGH = 2'h2,
        PTU_PIN_TOGGLE = 2'h3
    } ptu_pin_act_t;

endpackage : ptu_pkg

// file: sim/ptu_event_props.sv
// Port-level checks of the timer event logic.
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module ptu_event_props
    import ptu_pkg::*;
#(
    parameter logic [2:0] XFER_MASK = `PTU_XFER_MASK_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ptu_bus_t bus,
    input wire logic [5:0] count_tick,
    input wire logic [15:0] capture_in,
    input wire logic [15:0] xfer_start,
    input wire logic [5:0] dma_start,
    input wire logic [15:0] capture_match_irq,
    input wire logic [5:0] overflow_irq,
    input wire logic [5:0] underflow_irq,
    input wire logic [15:0] xfer_req,
    input wire logic [5:0] dma_req,
    input wire logic adc_start,
    input wire logic [15:0] timer_io_pin
);
    // ****************************************************************
    // Mask window after a transfer start
    // ****************************************************************
    // Only the lower bound is tracked, since a late end may stretch it.
    logic [2:0] msk_r;
    logic [2:0] msk_nxt;
    always_comb
    begin
        msk_nxt = (msk_r != 3'h0) ? msk_r - 3'h1 : 3'h0;
        if (xfer_start[0])
            msk_nxt = XFER_MASK - 3'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            msk_r <= 3'h0;
        else
            msk_r <= msk_nxt;
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_xfer_go;
        xfer_start[0] && xfer_req[0];
    endsequence
    sequence s_dma_go;
        dma_start[0] && dma_req[0];
    endsequence
    chk_udf_absent: assert property (underflow_irq[0] == 1'b0 &&
        underflow_irq[3] == 1'b0) else $error("underflow on ch0 or ch3");
    chk_xfer_drop: assert property (s_xfer_go |=> !xfer_req[0])
        else $error("transfer request kept after start");
    chk_xfer_mask: assert property (msk_r != 3'h0 |-> !xfer_req[0])
        else $error("transfer request inside mask window");
    chk_dma_drop: assert property (s_dma_go |=> !dma_req[0])
        else $error("dma request kept after start");
    chk_pin_cause: assert property ($changed(timer_io_pin) |->
        $past(count_tick) != 6'h00) else $error("pin moved without tick");
    chk_ovf_cause: assert property (
        (overflow_irq & ~$past(overflow_irq)) != 6'h00 |->
        ($past(count_tick) != 6'h00 || $past(count_tick, 2) != 6'h00 ||
        $past(bus.wr) || $past(bus.wr, 2)))
        else $error("overflow request without cause");
    chk_ovf_clear: assert property (
        (~overflow_irq & $past(overflow_irq)) != 6'h00 |->
        ($past(bus.wr) || $past(bus.wr, 2)))
        else $error("overflow request dropped without write");
    chk_cm_cause: assert property (
        (capture_match_irq & ~$past(capture_match_irq)) != 16'h0000 |->
        ($past(count_tick) != 6'h00 || $past(count_tick, 2) != 6'h00 ||
        $past(capture_in) != 16'h0000 || $past(bus.wr) || $past(bus.wr, 2)))
        else $error("match request without cause");
    chk_cm_clear: assert property (
        (~capture_match_irq & $past(capture_match_irq)) != 16'h0000 |->
        ($past(bus.wr) || $past(bus.wr, 2) || $past(xfer_start) != 16'h0
        || $past(dma_start) != 6'h00 || $past(xfer_start, 2) != 16'h0 ||
        $past(dma_start, 2) != 6'h00))
        else $error("match request dropped without cause");
    chk_adc_cause: assert property (adc_start |->
        ($past(count_tick) != 6'h00 || $past(count_tick, 2) != 6'h00 ||
        $past(capture_in) != 16'h0000))
        else $error("conversion start without event");
endmodule : ptu_event_props

// file: sim/ptu_xfer_model.sv
// Transfer engine stand-in that serves timer requests one at a time.
`timescale 1ns/1ps
module ptu_xfer_model
    import ptu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic [15:0] xfer_req,
    input wire logic [5:0] dma_req,
    output logic [15:0] xfer_start,
    output logic [15:0] xfer_end,
    output logic [5:0] dma_start,
    output logic [5:0] dma_end
);
    logic [21:0] req;
    logic [21:0] sel_r;
    logic [21:0] sel_nxt;
    logic [21:0] go_r;
    logic [21:0] go_nxt;
    logic [21:0] fin_r;
    logic [21:0] fin_nxt;
    logic [3:0] wait_r;
    logic [3:0] wait_nxt;
    assign req = {dma_req, xfer_req};
    assign {dma_start, xfer_start} = go_r;
    assign {dma_end, xfer_end} = fin_r;
    always_comb
    begin
        go_nxt = 22'h0;
        fin_nxt = 22'h0;
        sel_nxt = sel_r;
        wait_nxt = wait_r;
        if (sel_r == 22'h0 && req != 22'h0)
        begin
            sel_nxt = req & (~req + 22'h1);
            go_nxt = sel_nxt;
            // A slow transfer ends after the mask so the later bound rules.
            wait_nxt = slow ? 4'h9 : 4'h1;
        end
        else if (sel_r != 22'h0 && wait_r != 4'h0)
            wait_nxt = wait_r - 4'h1;
        else if (sel_r != 22'h0)
        begin
            fin_nxt = sel_r;
            sel_nxt = 22'h0;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_r <= 22'h0;
            go_r <= 22'h0;
            fin_r <= 22'h0;
            wait_r <= 4'h0;
        end
        else
        begin
            sel_r <= sel_nxt;
            go_r <= go_nxt;
            fin_r <= fin_nxt;
            wait_r <= wait_nxt;
        end
    end
endmodule : ptu_xfer_model

// file: sim/tb.sv
// Self-checking bench of the timer event logic.
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module tb
    import ptu_pkg::*;
;
    logic ref_clk;
    logic rst_b;
    logic slow;
    ptu_bus_t bus;
    logic [5:0] count_tick, count_down, overflow_irq, underflow_irq;
    logic [5:0] dma_start, dma_end, dma_req;
    logic [15:0] capture_in, xfer_start, xfer_end, rdata, xfer_req;
    logic [15:0] capture_match_irq, timer_io_pin, v, n, r;
    logic adc_start;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n_go = 0, n_adc = 0;
    int seed;
    ptu_event_logic #(.XFER_MASK(3'h5)) dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .bus(bus), .count_tick(count_tick),
        .count_down(count_down), .capture_in(capture_in),
        .xfer_start(xfer_start), .xfer_end(xfer_end),
        .dma_start(dma_start), .dma_end(dma_end), .rdata(rdata),
        .capture_match_irq(capture_match_irq), .overflow_irq(overflow_irq),
        .underflow_irq(underflow_irq), .xfer_req(xfer_req),
        .dma_req(dma_req), .adc_start(adc_start),
        .timer_io_pin(timer_io_pin));
    ptu_xfer_model u_xfer (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow),
        .xfer_req(xfer_req), .dma_req(dma_req), .xfer_start(xfer_start),
        .xfer_end(xfer_end), .dma_start(dma_start), .dma_end(dma_end));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (xfer_start[0] || dma_start[0])
            n_go <= n_go + 1;
        if (adc_start)
            n_adc <= n_adc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic [7:0] a, input logic [15:0] d,
        input logic w = 1'b1, input logic [5:0] t = 6'h00,
        input logic [15:0] c = 16'h0000);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: 1'b0};
        count_tick <= t;
        capture_in <= c;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        count_tick <= 6'h00;
        capture_in <= 16'h0000;
        #1;
    endtask : acc
    task automatic tick(input logic [5:0] t);
        acc(8'h00, 16'h0000, 1'b0, t);
    endtask : tick
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial
    begin
        seed = 32'h81c62f57;
        rst_b = 1'b0;
        bus = '0;
        count_tick = 6'h00;
        count_down = 6'h00;
        capture_in = 16'h0000;
        slow = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        acc(8'h04, 16'h1234);
        acc(`PTU_ADDR_MSTOP, 16'h0000);
        rd(8'h04, v);
        chk("gr_stopped", 16'h0000, v);
        $display("test stop done");
        n = 16'h0001 + 16'($unsigned($random(seed)) % 6);
        acc(8'h04, n);
        acc(8'h01, 16'h0001);
        acc(8'h08, 16'h0004);
        acc(8'h00, 16'h0011);
        repeat (n) tick(6'h01);
        chk("pin_early", 16'h0000, timer_io_pin);
        tick(6'h01);
        rd(8'h02, v);
        chk("flag_a", 16'h0001, v & 16'h0001);
        chk("irq_a", 16'h0001, capture_match_irq);
        chk("pin_a", 16'h0001, timer_io_pin);
        rd(8'h03, v);
        chk("cnt_wrap", 16'h0000, v);
        acc(8'h02, 16'h0000);
        settle;
        chk("irq_clr", 16'h0000, capture_match_irq);
        repeat (n + 1) tick(6'h01);
        acc(8'h02, 16'h0000);
        settle;
        chk("irq_unarmed", 16'h0001, capture_match_irq);
        rd(8'h02, v);
        acc(8'h02, 16'h0000);
        settle;
        chk("irq_armed", 16'h0000, capture_match_irq);
        $display("test compare done");
        slow <= 1'($random(seed));
        acc(8'h01, 16'h0101);
        repeat (n + 1) tick(6'h01);
        repeat (14) @(posedge ref_clk);
        rd(8'h02, v);
        chk("flag_xfer", 16'h0000, v & 16'h0001);
        acc(8'h01, 16'h00C1);
        repeat (n + 1) tick(6'h01);
        repeat (14) @(posedge ref_clk);
        rd(8'h02, v);
        chk("flag_dma", 16'h0000, v & 16'h0001);
        chk("starts", 16'h0002, 16'(n_go));
        chk("adc", 16'h0001, 16'(n_adc));
        $display("test transfer done");
        acc(8'h10, 16'h0010);
        acc(8'h11, 16'h0030);
        acc(8'h13, 16'hFFFF);
        tick(6'h02);
        settle;
        chk("ovf", 16'h0002, {10'h000, overflow_irq});
        rd(8'h12, v);
        acc(8'h12, 16'h0000);
        settle;
        chk("ovf_clr", 16'h0000, {10'h000, overflow_irq});
        count_down <= 6'h02;
        tick(6'h02);
        settle;
        chk("udf", 16'h0002, {10'h000, underflow_irq});
        rd(8'h12, v);
        acc(8'h12, 16'h0000);
        count_down <= 6'h00;
        acc(8'h13, 16'hFFFF);
        acc(8'h13, 16'h0007, 1'b1, 6'h02);
        settle;
        chk("ovf_wr", 16'h0000, {10'h000, overflow_irq});
        rd(8'h13, v);
        chk("cnt_wr", 16'h0007, v);
        $display("test overflow done");
        acc(8'h01, 16'h0010);
        acc(8'h03, n);
        acc(8'h03, 16'h0009, 1'b1, 6'h01);
        rd(8'h03, v);
        chk("clr_wr", 16'h0000, v);
        acc(8'h04, 16'hFFFF);
        acc(8'h03, 16'hFFFF);
        tick(6'h01);
        settle;
        chk("ovf_clr0", 16'h0000, {10'h000, overflow_irq});
        r = 16'($random(seed));
        acc(8'h28, 16'h0001);
        acc(8'h20, 16'h0010);
        acc(8'h23, r);
        acc(8'h24, ~r, 1'b1, 6'h00, 16'h0040);
        rd(8'h24, v);
        chk("cap_wr", r, v);
        $display("test conflict done");
        conclude();
    end
endmodule : tb
bind ptu_event_logic ptu_event_props #(.XFER_MASK(XFER_MASK)) u_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .count_tick(count_tick),
    .capture_in(capture_in), .xfer_start(xfer_start),
    .dma_start(dma_start), .capture_match_irq(capture_match_irq),
    .overflow_irq(overflow_irq), .underflow_irq(underflow_irq),
    .xfer_req(xfer_req), .dma_req(dma_req), .adc_start(adc_start),
    .timer_io_pin(timer_io_pin));
